//--- core/pll_clock_control_regs.vh
// Register offsets, field positions and reset values of the loop control block
`ifndef PLL_CLOCK_CONTROL_REGS_VH
`define PLL_CLOCK_CONTROL_REGS_VH

`define PLL_CONTROL_ADDR      8'ha3
`define PLL_DIVIDER_ADDR      8'ha4
`define PLL_CONTROL_RESET     8'h00
`define PLL_DIVIDER_RESET     8'h00
`define BYPASS_BIT            2
`define ENABLE_BIT            1
`define LOCK_BIT              0
`define REF_DIV_MSB           7
`define REF_DIV_LSB           4
`define FB_DIV_MSB            3
`define FB_DIV_LSB            0

`endif

//--- core/lock_sync.v
// Two-stage synchroniser for the analog lock level
`timescale 1ns/100ps
`default_nettype none

module lock_sync (
	input  wire clk,
	input  wire rst,
	input  wire levelIn,
	output reg  levelOut
);

	reg stage1_r;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1_r <= 1'b0;
			levelOut <= 1'b0;
		end else begin
			stage1_r <= levelIn;
			levelOut <= stage1_r;
		end
	end

endmodule // lock_sync

`default_nettype wire

//--- core/pll_clock_control.v
// Special-function registers that control the on-chip clock synthesis loop
//
// Contract
// - Bits 7 to 3 of the control register read zero and software must not set them.
// - The bypass bit set selects the external clock and stops the crystal; clear selects the loop output.
// - Writing one to the enable bit turns the loop on and writing zero turns it off.
// - The lock indicator follows the loop's lock state and ignores software writes.
// - After reset the control register reads all zeros: disabled, not bypassed, unlocked.
// - The divider register holds the reference divider in bits 7-4 and feedback divider in 3-0, reset zero.
`timescale 1ns/100ps
`default_nettype none
`include "pll_clock_control_regs.vh"

module pll_clock_control (
	input  wire       clk,
	input  wire       rst,
	input  wire [7:0] sfrAddr,
	input  wire [7:0] sfrWdata,
	input  wire       sfrWr,
	input  wire       sfrRd,
	output reg  [7:0] sfrRdata,
	output reg        sfrHit,
	input  wire       loopLocked,
	output reg        loopEnable,
	output reg        externalClockBypass,
	output reg        crystalEnable,
	output reg  [3:0] referenceDivider,
	output reg  [3:0] feedbackDivider
);

	localparam [7:0] CONTROL_RESET = `PLL_CONTROL_RESET;
	localparam [7:0] DIVIDER_RESET = `PLL_DIVIDER_RESET;

	wire       lockSynced;
	wire [7:0] controlView;
	wire [7:0] dividerView;
	wire       ctlWrite;
	wire       divWrite;
	wire       anyAccess;
	reg  [7:0] readMux;

	// Next values, decoded combinationally and loaded on the clock
	reg        externalClockBypass_nxt;
	reg        crystalEnable_nxt;
	reg        loopEnable_nxt;
	reg  [3:0] referenceDivider_nxt;
	reg  [3:0] feedbackDivider_nxt;
	reg  [7:0] sfrRdata_nxt;
	reg        sfrHit_nxt;

	genvar bitIdx;

	// The lock pin is asynchronous to clk; only the second stage is read
	lock_sync uLockSync (
		.clk      (clk),
		.rst      (rst),
		.levelIn  (loopLocked),
		.levelOut (lockSynced)
	);

	// Address decode shared by the write strobes, the read mux and the hit flag
	function isControl;
		input [7:0] addr;
		begin
			isControl = (addr == `PLL_CONTROL_ADDR);
		end
	endfunction

	function isDivider;
		input [7:0] addr;
		begin
			isDivider = (addr == `PLL_DIVIDER_ADDR);
		end
	endfunction

	function isReg;
		input [7:0] addr;
		begin
			isReg = isControl(addr) || isDivider(addr);
		end
	endfunction

	assign ctlWrite  = sfrWr && isControl(sfrAddr);
	assign divWrite  = sfrWr && isDivider(sfrAddr);
	assign anyAccess = sfrRd || sfrWr;

	// Control register read view, one bit position at a time
	generate
		for (bitIdx = 0; bitIdx < 8; bitIdx = bitIdx + 1) begin : gControlView
			if (bitIdx == `BYPASS_BIT) begin : gBypass
				assign controlView[bitIdx] = externalClockBypass;
			end else if (bitIdx == `ENABLE_BIT) begin : gEnable
				assign controlView[bitIdx] = loopEnable;
			end else if (bitIdx == `LOCK_BIT) begin : gLock
				// Live view of the loop, so a write cannot disturb it
				assign controlView[bitIdx] = lockSynced;
			end else begin : gReserved
				// Tied off so that no later field can leak into a read
				assign controlView[bitIdx] = 1'b0;
			end
		end
	endgenerate

	// Divider register read view
	assign dividerView[`REF_DIV_MSB:`REF_DIV_LSB] = referenceDivider;
	assign dividerView[`FB_DIV_MSB:`FB_DIV_LSB]   = feedbackDivider;

	// Unmapped addresses read as zero
	always @* begin
		readMux = 8'h00;
		if (isControl(sfrAddr)) begin
			readMux = controlView;
		end else if (isDivider(sfrAddr)) begin
			readMux = dividerView;
		end
	end

	always @* begin
		externalClockBypass_nxt = externalClockBypass;
		crystalEnable_nxt       = crystalEnable;
		// Reserved and lock positions of the written byte are discarded
		if (ctlWrite) begin
			externalClockBypass_nxt = sfrWdata[`BYPASS_BIT];
			crystalEnable_nxt       = ~sfrWdata[`BYPASS_BIT];
		end
	end

	// Turning the loop off leaves the dividers alone; the same write reloads the clock selection from its bypass bit
	always @* begin
		loopEnable_nxt = loopEnable;
		if (ctlWrite) begin
			loopEnable_nxt = sfrWdata[`ENABLE_BIT];
		end
	end

	// The loop sees new ratios at once, so they should be set while it is off
	always @* begin
		referenceDivider_nxt = referenceDivider;
		feedbackDivider_nxt  = feedbackDivider;
		if (divWrite) begin
			referenceDivider_nxt = sfrWdata[`REF_DIV_MSB:`REF_DIV_LSB];
			feedbackDivider_nxt  = sfrWdata[`FB_DIV_MSB:`FB_DIV_LSB];
		end
	end

	// A read in the same cycle as a write returns the value before the write
	always @* begin
		sfrRdata_nxt = sfrRdata;
		if (sfrRd) begin
			sfrRdata_nxt = readMux;
		end
	end

	// Hit acknowledges the core; unmapped addresses leave it low
	always @* begin
		sfrHit_nxt = 1'b0;
		if (anyAccess && isReg(sfrAddr)) begin
			sfrHit_nxt = 1'b1;
		end
	end

	// Bypass and crystal gate come from one write, so they never disagree
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			externalClockBypass <= CONTROL_RESET[`BYPASS_BIT];
		end else begin
			externalClockBypass <= externalClockBypass_nxt;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			crystalEnable <= ~CONTROL_RESET[`BYPASS_BIT];
		end else begin
			crystalEnable <= crystalEnable_nxt;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			loopEnable <= CONTROL_RESET[`ENABLE_BIT];
		end else begin
			loopEnable <= loopEnable_nxt;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			referenceDivider <= DIVIDER_RESET[`REF_DIV_MSB:`REF_DIV_LSB];
		end else begin
			referenceDivider <= referenceDivider_nxt;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			feedbackDivider <= DIVIDER_RESET[`FB_DIV_MSB:`FB_DIV_LSB];
		end else begin
			feedbackDivider <= feedbackDivider_nxt;
		end
	end

	// Read data holds until the next read, so the core may take it late
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sfrRdata <= 8'h00;
		end else begin
			sfrRdata <= sfrRdata_nxt;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sfrHit <= 1'b0;
		end else begin
			sfrHit <= sfrHit_nxt;
		end
	end

endmodule // pll_clock_control

`default_nettype wire

//--- verif/pll_clock_control_properties.sv
// Port checker for the loop control registers
`timescale 1ns/100ps
`default_nettype none
module pll_clock_control_properties (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       sfrRd,
	input wire logic       sfrWr,
	input wire logic       sfrHit,
	input wire logic       loopLocked,
	input wire logic       loopEnable,
	input wire logic       externalClockBypass,
	input wire logic       crystalEnable,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	input wire logic [7:0] sfrRdata,
	input wire logic [3:0] referenceDivider,
	input wire logic [3:0] feedbackDivider
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_rsv; sfrRd && sfrAddr == 8'ha3 |=> sfrRdata[7:3] == 5'h00; endproperty
	property p_byp; sfrWr && sfrAddr == 8'ha3 |=>
		externalClockBypass == $past(sfrWdata[2]) && crystalEnable != externalClockBypass; endproperty
	property p_en; sfrWr && sfrAddr == 8'ha3 |=> loopEnable == $past(sfrWdata[1]); endproperty
	property p_div; sfrWr && sfrAddr == 8'ha4 |=>
		referenceDivider == $past(sfrWdata[7:4]) && feedbackDivider == $past(sfrWdata[3:0]); endproperty
	// Lock reaches the read data through two synchroniser stages and the read register
	property p_lock; sfrRd && sfrAddr == 8'ha3 |=> sfrRdata[0] == $past(loopLocked, 3); endproperty
	property p_rst; $fell(rst) |-> !loopEnable && !externalClockBypass && crystalEnable &&
		referenceDivider == 4'h0 && feedbackDivider == 4'h0; endproperty
	property p_hit; (sfrRd || sfrWr) && (sfrAddr == 8'ha3 || sfrAddr == 8'ha4) |=> sfrHit; endproperty
	property p_nohit; !((sfrRd || sfrWr) && (sfrAddr == 8'ha3 || sfrAddr == 8'ha4)) |=> !sfrHit;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits read set");
	a_byp: assert property (p_byp) else $error("bypass wrong");
	a_en: assert property (p_en) else $error("enable wrong");
	a_div: assert property (p_div) else $error("divider wrong");
	a_lock: assert property (p_lock) else $error("lock bit wrong");
	a_rst: assert property (p_rst) else $error("reset value wrong");
	a_hit: assert property (p_hit) else $error("hit missing");
	a_nohit: assert property (p_nohit) else $error("hit without mapped access");
	c_ctl: cover property (sfrWr && sfrAddr == 8'ha3);
	c_div: cover property (sfrWr && sfrAddr == 8'ha4);
	c_on: cover property (loopEnable && externalClockBypass);
endmodule // pll_clock_control_properties
bind pll_clock_control pll_clock_control_properties u_pll_clock_control_properties (
	.clk                 (clk),
	.rst                 (rst),
	.sfrRd               (sfrRd),
	.sfrWr               (sfrWr),
	.sfrHit              (sfrHit),
	.loopLocked          (loopLocked),
	.loopEnable          (loopEnable),
	.externalClockBypass (externalClockBypass),
	.crystalEnable       (crystalEnable),
	.sfrAddr             (sfrAddr),
	.sfrWdata            (sfrWdata),
	.sfrRdata            (sfrRdata),
	.referenceDivider    (referenceDivider),
	.feedbackDivider     (feedbackDivider)
);
`default_nettype wire

//--- verif/tb_top.sv
// Register bench for the loop control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sfrWr = 1'b0;
	logic        sfrRd = 1'b0;
	logic        loopLocked = 1'b0;
	logic        sfrHit;
	logic        loopEnable;
	logic        externalClockBypass;
	logic        crystalEnable;
	logic [7:0]  sfrAddr = 8'h00;
	logic [7:0]  sfrWdata = 8'h00;
	logic [7:0]  sfrRdata;
	logic [3:0]  referenceDivider;
	logic [3:0]  feedbackDivider;
	// Row: address, write data, read-back, pins {0, bypass, enable, crystal, ref, fb}
	logic [35:0] rows [4] = '{36'ha45a5a15a, 36'ha3070665a, 36'ha3000015a, 36'ha9ff0015a};
	int          n_mismatch = 0;
	int          compares = 0;
	int          cyc = 0;
	pll_clock_control u_pll_clock_control (
		.clk                 (clk),
		.rst                 (rst),
		.sfrAddr             (sfrAddr),
		.sfrWdata            (sfrWdata),
		.sfrWr               (sfrWr),
		.sfrRd               (sfrRd),
		.sfrRdata            (sfrRdata),
		.sfrHit              (sfrHit),
		.loopLocked          (loopLocked),
		.loopEnable          (loopEnable),
		.externalClockBypass (externalClockBypass),
		.crystalEnable       (crystalEnable),
		.referenceDivider    (referenceDivider),
		.feedbackDivider     (feedbackDivider)
	);
	always #50 clk = ~clk;
	function automatic logic [11:0] pins();
		return {1'b0, externalClockBypass, loopEnable, crystalEnable, referenceDivider,
			feedbackDivider};
	endfunction
	function automatic logic mapped(input logic [7:0] a);
		return a == 8'ha3 || a == 8'ha4;
	endfunction
	task check(input logic [11:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask
	task acc(input logic [7:0] a, d, input logic w);
		@(posedge clk);
		#1 sfrAddr = a; sfrWdata = d; sfrWr = w; sfrRd = !w;
		@(posedge clk);
		#1 sfrWr = 0; sfrRd = 0;
	endtask
	task chk(input logic [7:0] a, e);
		acc(a, 8'h00, 1'b0);
		check({4'h0, sfrRdata}, {4'h0, e});
		check({11'h000, sfrHit}, {11'h000, mapped(a)});
	endtask
	task stop_test;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard, far above the few dozen cycles the run needs
	always @(posedge clk) if (++cyc > 500) begin
		n_mismatch++;
		stop_test;
	end
	initial begin
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		check(pins(), 12'h100);
		chk(8'ha3, 8'h00);
		chk(8'ha4, 8'h00);
		$display("reset test done");
		// Dividers are programmed before the loop is enabled
		foreach (rows[i]) begin
			acc(rows[i][35:28], rows[i][27:20], 1'b1);
			check(pins(), rows[i][11:0]);
			check({11'h000, sfrHit}, {11'h000, mapped(rows[i][35:28])});
			chk(rows[i][35:28], rows[i][19:12]);
		end
		$display("row test done");
		// Lock follows the pin two edges late and ignores writes of bit 0
		loopLocked = 1'b1;
		acc(8'ha3, 8'h02, 1'b1);
		chk(8'ha3, 8'h03);
		loopLocked = 1'b0;
		repeat (2) @(posedge clk);
		chk(8'ha3, 8'h02);
		$display("lock test done");
		// Second reset in mid-run, with the loop enabled and the dividers set
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		check(pins(), 12'h100);
		chk(8'ha3, 8'h00);
		chk(8'ha4, 8'h00);
		$display("mid-run reset test done");
		stop_test;
	end
endmodule // tb_top
`default_nettype wire
